// >>> febs_pkg.sv
// Package of event codes, carriers and timing constants for the front-end event selector.
package febs_pkg;

    localparam logic [7:0] EVT_ITLB      = 8'h82;
    localparam logic [7:0] UM_INSTR_TLB_FLUSH_EVENT = 8'h40;
    localparam logic [7:0] UM_ITLB_MISS  = 8'h12;
    localparam logic [7:0] EVT_QFULL     = 8'h83;
    localparam logic [7:0] UM_QFULL      = 8'h02;
    localparam logic [7:0] EVT_FSTALL    = 8'h86;
    localparam logic [7:0] EVT_LDSLOW    = 8'h87;
    localparam logic [7:0] EVT_BR_EXEC   = 8'h88;
    localparam logic [7:0] EVT_BR_MISP   = 8'h89;
    localparam logic [7:0] EVT_BR_DMISP  = 8'h8A;
    localparam logic [7:0] EVT_CBR_EXEC  = 8'h8B;
    localparam logic [7:0] EVT_CBR_MISP  = 8'h8C;
    localparam logic [7:0] EVT_IBR_EXEC  = 8'h8D;
    localparam logic [7:0] UM_NONE       = 8'h00;
    localparam logic [7:0] PFX_OPSIZE    = 8'h66;
    localparam logic [7:0] PFX_ADSIZE    = 8'h67;

    // Slow length decode occupies this many cycles; the fast path one.
    localparam int         SLOW_DECODE_CYCLES = 6;
    localparam logic [2:0] SLOW_LAST = 3'(SLOW_DECODE_CYCLES - 1);
    localparam logic [2:0] CNT_ZERO  = 3'h0;
    localparam logic [2:0] CNT_ONE   = 3'h1;

    typedef enum logic [1:0] {
        FEBS_MODE_REAL    = 2'b00,
        FEBS_MODE_BIGREAL = 2'b01,
        FEBS_MODE_PROT16  = 2'b10,
        FEBS_MODE_PROT32  = 2'b11
    } febs_mode_e;

    typedef struct packed {
        logic [7:0] event_num;
        logic [7:0] unit_mask;
    } febs_sel_s;

    // One-cycle pulses or levels from the pipeline.
    typedef struct packed {
        logic instr_tlb_flush_event;
        logic instr_tlb_miss_small;
        logic instr_tlb_miss_large;
        logic fetch_queue_full_event;
        logic fetch_stall_cycles_event;
        logic branch_executed_event;
        logic branch_is_uop;
        logic branch_mispredict_event;
        logic branch_decode_mispredict_event;
        logic cond_branch_executed_event;
        logic cond_branch_mispredict_event;
        logic indirect_branch_executed_event;
    } febs_evt_s;

    // One instruction offered to the length decoder.
    typedef struct packed {
        logic       valid;
        logic [7:0] prefix;
        logic       has_prefix;
        logic       has_imm;
        logic       has_modrm;
        febs_mode_e mode;
    } febs_insn_s;

    typedef enum logic [1:0] {
        FEBS_LD_IDLE = 2'b00,
        FEBS_LD_SLOW = 2'b01
    } febs_ld_e;

    typedef struct packed {
        febs_ld_e   ld_state;
        logic [2:0] ld_cnt;
        logic       ld_done;
        logic       ld_slow;
        logic       fetch_en;
        logic       count_inc;
    } febs_state_s;

endpackage

// >>> febs_event_select.sv
// Front-end and branch event selector with length-decoder timing and fetch gating.
`timescale 1ns/1ps

// Summary of operation
// R1: Flush code 82H/40H counts one per instruction TLB flush.
// R2: Miss code 82H/12H counts every instruction TLB miss, small or large page.
// R3: Queue-full code 83H/02H counts every cycle the instruction queue is full.
// R4: Fetching is stopped while the instruction queue is full.
// R5: Fetch-stall code 86H/00H counts every cycle an instruction fetch is stalled.
// R6: Code 87H/00H counts every cycle the length decoder runs its slow path.
// R7: Length decode takes one cycle normally and six cycles on the slow path.
// R8: An operand-size prefix 66H before an instruction with immediate data selects the slow path.
// R9: An address-size prefix 67H before a modr/m instruction selects the slow path in all modes.
// R10: Code 88H/00H counts executed branch instructions, excluding micro-op branches.
// R11: Code 89H/00H counts executed mispredicted branches.
// R12: Code 8AH/00H counts branches mispredicted at decode.
// R13: Code 8BH/00H counts executed conditional branches.
// R14: Code 8CH/00H counts executed mispredicted conditional branches.
// R15: Code 8DH/00H counts executed indirect branches.
// R16: A source reaches the counter only when both event number and unit mask match its code.
module febs_event_select (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 arst_n,
    // Selection and pipeline events
    input  wire febs_pkg::febs_sel_s  sel,
    input  wire febs_pkg::febs_evt_s  evt,
    // Length decoder request
    input  wire febs_pkg::febs_insn_s insn,
    // Outputs
    output logic                      count_inc,
    output logic                      fetch_en,
    output logic                      ld_slow,
    output logic                      ld_done
);
    import febs_pkg::*;

    febs_state_s state_reg;
    febs_state_s state_next;

    function automatic logic code_is(input febs_sel_s s, input logic [7:0] ev,
                                     input logic [7:0] um);
        code_is = (s.event_num == ev) && (s.unit_mask == um); // R16
    endfunction

    function automatic logic needs_slow(input febs_insn_s i);
        logic op;
        logic ad;
        op = i.has_prefix && (i.prefix == PFX_OPSIZE) && i.has_imm; // R8
        // Every mode encoding is one of the four slow-path modes.
        ad = i.has_prefix && (i.prefix == PFX_ADSIZE) && i.has_modrm; // R9
        needs_slow = i.valid && (op || ad);
    endfunction

    // The codes are all distinct, so the order of this chain never changes the result.
    function automatic logic select_hit(input febs_sel_s s, input febs_evt_s e,
                                        input logic slow_busy, input logic slow_offer);
        select_hit = 1'b0;
        if (code_is(s, EVT_ITLB, UM_INSTR_TLB_FLUSH_EVENT)) begin
            select_hit = e.instr_tlb_flush_event; // R1
        end else if (code_is(s, EVT_ITLB, UM_ITLB_MISS)) begin
            // Both page sizes in one cycle still make a single increment.
            select_hit = e.instr_tlb_miss_small || e.instr_tlb_miss_large; // R2
        end else if (code_is(s, EVT_QFULL, UM_QFULL)) begin
            select_hit = e.fetch_queue_full_event; // R3
        end else if (code_is(s, EVT_FSTALL, UM_NONE)) begin
            select_hit = e.fetch_stall_cycles_event; // R5
        end else if (code_is(s, EVT_LDSLOW, UM_NONE)) begin
            // The offer cycle counts as well, so one slow decode adds six.
            select_hit = slow_busy || slow_offer; // R6
        end else if (code_is(s, EVT_BR_EXEC, UM_NONE)) begin
            select_hit = e.branch_executed_event && !e.branch_is_uop; // R10
        end else if (code_is(s, EVT_BR_MISP, UM_NONE)) begin
            select_hit = e.branch_mispredict_event; // R11
        end else if (code_is(s, EVT_BR_DMISP, UM_NONE)) begin
            select_hit = e.branch_decode_mispredict_event; // R12
        end else if (code_is(s, EVT_CBR_EXEC, UM_NONE)) begin
            select_hit = e.cond_branch_executed_event; // R13
        end else if (code_is(s, EVT_CBR_MISP, UM_NONE)) begin
            select_hit = e.cond_branch_mispredict_event; // R14
        end else if (code_is(s, EVT_IBR_EXEC, UM_NONE)) begin
            select_hit = e.indirect_branch_executed_event; // R15
        end
    endfunction

    always_comb begin
        state_next           = state_reg;
        state_next.count_inc = select_hit(sel, evt, state_reg.ld_state == FEBS_LD_SLOW,
                                          needs_slow(insn)); // R16
        // Fetch permission follows the queue one cycle late, like every other output.
        state_next.fetch_en  = !evt.fetch_queue_full_event; // R4
        state_next.ld_done   = 1'b0;
        case (state_reg.ld_state)
            FEBS_LD_IDLE: begin
                if (needs_slow(insn)) begin
                    state_next.ld_state = FEBS_LD_SLOW;
                    state_next.ld_cnt   = CNT_ONE;
                    state_next.ld_slow  = 1'b1;
                end else begin
                    state_next.ld_done  = insn.valid; // R7
                    state_next.ld_slow  = 1'b0;
                end
            end
            FEBS_LD_SLOW: begin
                // The decoder accepts no new instruction until the slow decode ends.
                if (state_reg.ld_cnt == SLOW_LAST) begin
                    state_next.ld_state = FEBS_LD_IDLE;
                    state_next.ld_cnt   = CNT_ZERO;
                    state_next.ld_done  = 1'b1; // R7
                    state_next.ld_slow  = 1'b0;
                end else begin
                    state_next.ld_cnt   = state_reg.ld_cnt + CNT_ONE;
                end
            end
            default: begin
                state_next.ld_state = FEBS_LD_IDLE;
                state_next.ld_cnt   = CNT_ZERO;
                state_next.ld_slow  = 1'b0;
            end
        endcase
    end

    // Reset leaves fetch enabled, since an empty queue cannot be full.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '{ld_state: FEBS_LD_IDLE, ld_cnt: CNT_ZERO, ld_done: 1'b0,
                           ld_slow: 1'b0, fetch_en: 1'b1, count_inc: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign count_inc = state_reg.count_inc;
    assign fetch_en  = state_reg.fetch_en;
    assign ld_slow   = state_reg.ld_slow;
    assign ld_done   = state_reg.ld_done;

    sequence s_slow_start;
        !ld_slow ##1 ld_slow;
    endsequence

    sequence s_slow_body;
        ld_slow [*5] ##1 (!ld_slow && ld_done);
    endsequence

    a_slow_six_cycles: assert property (@(posedge clk_sys) disable iff (!arst_n) // R7
        s_slow_start |-> s_slow_body)
        else $error("slow decode did not last six cycles");

    a_fast_one_cycle: assert property (@(posedge clk_sys) disable iff (!arst_n) // R7
        (state_reg.ld_state == FEBS_LD_IDLE && insn.valid && !needs_slow(insn)) |=> ld_done)
        else $error("fast decode did not finish in one cycle");

    a_opsize_slow: assert property (@(posedge clk_sys) disable iff (!arst_n) // R8
        (!ld_slow && insn.valid && insn.has_prefix && insn.prefix == PFX_OPSIZE
         && insn.has_imm) |=> ld_slow)
        else $error("operand-size prefix with immediate did not go slow");

    a_adsize_slow: assert property (@(posedge clk_sys) disable iff (!arst_n) // R9
        (!ld_slow && insn.valid && insn.has_prefix && insn.prefix == PFX_ADSIZE
         && insn.has_modrm) |=> ld_slow)
        else $error("address-size prefix with modr/m did not go slow");

    a_fetch_gate: assert property (@(posedge clk_sys) disable iff (!arst_n) // R4
        evt.fetch_queue_full_event |=> !fetch_en)
        else $error("fetch not stopped while queue full");

    a_flush_count: assert property (@(posedge clk_sys) disable iff (!arst_n) // R1
        (code_is(sel, EVT_ITLB, UM_INSTR_TLB_FLUSH_EVENT) && evt.instr_tlb_flush_event) |=> count_inc)
        else $error("flush not counted");

    a_miss_count: assert property (@(posedge clk_sys) disable iff (!arst_n) // R2
        (code_is(sel, EVT_ITLB, UM_ITLB_MISS) && evt.instr_tlb_miss_large) |=> count_inc)
        else $error("large page miss not counted");

    a_qfull_count: assert property (@(posedge clk_sys) disable iff (!arst_n) // R3
        (code_is(sel, EVT_QFULL, UM_QFULL) && evt.fetch_queue_full_event) |=> count_inc)
        else $error("queue full cycle not counted");

    a_stall_count: assert property (@(posedge clk_sys) disable iff (!arst_n) // R5
        (code_is(sel, EVT_FSTALL, UM_NONE) && evt.fetch_stall_cycles_event) |=> count_inc)
        else $error("fetch stall cycle not counted");

    a_ldslow_count: assert property (@(posedge clk_sys) disable iff (!arst_n) // R6
        (code_is(sel, EVT_LDSLOW, UM_NONE) && ld_slow) |=> count_inc)
        else $error("slow decode cycle not counted");

    a_uop_excluded: assert property (@(posedge clk_sys) disable iff (!arst_n) // R10
        (code_is(sel, EVT_BR_EXEC, UM_NONE) && evt.branch_is_uop) |=> !count_inc)
        else $error("micro-op branch counted");

    a_misp_count: assert property (@(posedge clk_sys) disable iff (!arst_n) // R11
        (code_is(sel, EVT_BR_MISP, UM_NONE) && evt.branch_mispredict_event) |=> count_inc)
        else $error("mispredict not counted");

    a_dmisp_count: assert property (@(posedge clk_sys) disable iff (!arst_n) // R12
        (code_is(sel, EVT_BR_DMISP, UM_NONE) && evt.branch_decode_mispredict_event)
        |=> count_inc)
        else $error("decode mispredict not counted");

    a_cond_count: assert property (@(posedge clk_sys) disable iff (!arst_n) // R13
        (code_is(sel, EVT_CBR_EXEC, UM_NONE) && evt.cond_branch_executed_event) |=> count_inc)
        else $error("conditional branch not counted");

    a_cmisp_count: assert property (@(posedge clk_sys) disable iff (!arst_n) // R14
        (code_is(sel, EVT_CBR_MISP, UM_NONE) && evt.cond_branch_mispredict_event)
        |=> count_inc)
        else $error("mispredicted conditional not counted");

    a_ind_count: assert property (@(posedge clk_sys) disable iff (!arst_n) // R15
        (code_is(sel, EVT_IBR_EXEC, UM_NONE) && evt.indirect_branch_executed_event)
        |=> count_inc)
        else $error("indirect branch not counted");

    a_nomatch_idle: assert property (@(posedge clk_sys) disable iff (!arst_n) // R16
        (sel.event_num == EVT_BR_EXEC && sel.unit_mask != UM_NONE) |=> !count_inc)
        else $error("counted with wrong unit mask");

    // A selected source that stays quiet must leave the count idle.
    a_flush_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n) // R1
        (code_is(sel, EVT_ITLB, UM_INSTR_TLB_FLUSH_EVENT) && !evt.instr_tlb_flush_event)
        |=> !count_inc)
        else $error("flush counted without a flush");

    a_miss_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n) // R2
        (code_is(sel, EVT_ITLB, UM_ITLB_MISS) && !evt.instr_tlb_miss_small
         && !evt.instr_tlb_miss_large) |=> !count_inc)
        else $error("miss counted without a miss");

    a_qfull_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n) // R3
        (code_is(sel, EVT_QFULL, UM_QFULL) && !evt.fetch_queue_full_event)
        |=> !count_inc)
        else $error("queue full counted while queue had room");

    a_stall_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n) // R5
        (code_is(sel, EVT_FSTALL, UM_NONE) && !evt.fetch_stall_cycles_event)
        |=> !count_inc)
        else $error("stall counted without a stall");

    a_ldslow_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n) // R6
        (code_is(sel, EVT_LDSLOW, UM_NONE) && !ld_slow && !needs_slow(insn))
        |=> !count_inc)
        else $error("slow decode counted on the fast path");

    a_brexec_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n) // R10
        (code_is(sel, EVT_BR_EXEC, UM_NONE) && !evt.branch_executed_event)
        |=> !count_inc)
        else $error("branch counted without a branch");

    a_misp_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n) // R11
        (code_is(sel, EVT_BR_MISP, UM_NONE) && !evt.branch_mispredict_event)
        |=> !count_inc)
        else $error("mispredict counted without a mispredict");

    a_dmisp_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n) // R12
        (code_is(sel, EVT_BR_DMISP, UM_NONE) && !evt.branch_decode_mispredict_event)
        |=> !count_inc)
        else $error("decode mispredict counted without one");

    a_cond_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n) // R13
        (code_is(sel, EVT_CBR_EXEC, UM_NONE) && !evt.cond_branch_executed_event)
        |=> !count_inc)
        else $error("conditional branch counted without one");

    a_cmisp_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n) // R14
        (code_is(sel, EVT_CBR_MISP, UM_NONE) && !evt.cond_branch_mispredict_event)
        |=> !count_inc)
        else $error("conditional mispredict counted without one");

    a_ind_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n) // R15
        (code_is(sel, EVT_IBR_EXEC, UM_NONE) && !evt.indirect_branch_executed_event)
        |=> !count_inc)
        else $error("indirect branch counted without one");

    a_miss_small: assert property (@(posedge clk_sys) disable iff (!arst_n) // R2
        (code_is(sel, EVT_ITLB, UM_ITLB_MISS) && evt.instr_tlb_miss_small) |=> count_inc)
        else $error("small page miss not counted");

    // Fetch must come back as soon as the queue has room again.
    a_fetch_resume: assert property (@(posedge clk_sys) disable iff (!arst_n) // R4
        !evt.fetch_queue_full_event |=> fetch_en)
        else $error("fetch not resumed after queue drained");

    // A slow decode never stops early, whatever is offered meanwhile.
    a_slow_no_abort: assert property (@(posedge clk_sys) disable iff (!arst_n) // R7
        ld_slow |=> (ld_slow || ld_done))
        else $error("slow decode left without finishing");

    a_done_not_slow: assert property (@(posedge clk_sys) disable iff (!arst_n) // R7
        !(ld_done && ld_slow))
        else $error("decode done while still on the slow path");

    // Unit masks that belong to no listed source must never reach the counter.
    a_foreign_code: assert property (@(posedge clk_sys) disable iff (!arst_n) // R16
        (sel.unit_mask != UM_NONE && sel.event_num != EVT_ITLB && sel.event_num != EVT_QFULL)
        |=> !count_inc)
        else $error("counted with a foreign unit mask");

    a_itlb_mask: assert property (@(posedge clk_sys) disable iff (!arst_n) // R16
        (sel.event_num == EVT_ITLB && sel.unit_mask != UM_INSTR_TLB_FLUSH_EVENT
         && sel.unit_mask != UM_ITLB_MISS) |=> !count_inc)
        else $error("counted with an unlisted translation mask");

endmodule

// >>> febs_pipe_model.sv
// Pipeline model that offers events and instructions to the event selector.
`timescale 1ns/1ps
module febs_pipe_model (
    // Clock
    input  wire logic            clk_sys,
    // Pipeline outputs
    output febs_pkg::febs_evt_s  evt,
    output febs_pkg::febs_insn_s insn
);
    import febs_pkg::*;

    initial begin
        evt  = '0;
        insn = '0;
    end

    // One cycle of pipeline activity, launched just after the edge.
    task automatic step(input febs_evt_s e, input febs_insn_s i);
        @(posedge clk_sys);
        #1;
        evt  = e;
        insn = i;
    endtask
endmodule

// >>> frontend_branch_event_select_test.sv
// Self-checking bench for the front-end and branch event selector.
`timescale 1ns/1ps
module frontend_branch_event_select_test;
    import febs_pkg::*;
    logic        clk_sys;
    logic        arst_n;
    febs_sel_s   sel;
    febs_evt_s   evt;
    febs_insn_s  insn;
    logic        count_inc;
    logic        fetch_en;
    logic        ld_slow;
    logic        ld_done;
    int          mismatches;
    int          tests_run;

    febs_event_select u_febs_event_select (.clk_sys(clk_sys), .arst_n(arst_n), .sel(sel),
        .evt(evt), .insn(insn), .count_inc(count_inc), .fetch_en(fetch_en),
        .ld_slow(ld_slow), .ld_done(ld_done));
    febs_pipe_model u_febs_pipe_model (.clk_sys(clk_sys), .evt(evt), .insn(insn));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic got, input logic exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic febs_insn_s mk(input logic [7:0] p, input logic imm, input logic rm,
                                      input febs_mode_e md);
        mk = '{valid: 1'b1, prefix: p, has_prefix: 1'b1, has_imm: imm, has_modrm: rm, mode: md};
    endfunction

    // Each code except 87H against its source, plus micro-op and unit-mask mismatches.
    task automatic test_codes();
        logic [15:0] s [15] = '{16'h8240, 16'h8212, 16'h8212, 16'h8302, 16'h8600, 16'h8800,
            16'h8800, 16'h8900, 16'h8A00, 16'h8B00, 16'h8C00, 16'h8D00, 16'h8240, 16'h8801,
            16'h8202};
        logic [11:0] e [15] = '{12'h800, 12'h400, 12'h200, 12'h100, 12'h080, 12'h040,
            12'h060, 12'h010, 12'h008, 12'h004, 12'h002, 12'h001, 12'h400, 12'h040, 12'h400};
        logic        x [15] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1,
            1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        for (int k = 0; k < 15; k++) begin
            sel = s[k];
            u_febs_pipe_model.step(e[k], '0);
            u_febs_pipe_model.step('0, '0);
            chk(count_inc, x[k], "event code count");
        end
        $display("test_codes done");
    endtask

    // Queue full for three cycles: counted each cycle and fetch held off.
    task automatic test_queue_full();
        febs_evt_s q;
        q = '0;
        q.fetch_queue_full_event = 1'b1;
        sel = {EVT_QFULL, UM_QFULL};
        u_febs_pipe_model.step(q, '0);
        for (int n = 0; n < 3; n++) begin
            u_febs_pipe_model.step((n < 2) ? q : '0, '0);
            chk(count_inc, 1'b1, "queue full cycle count");
            chk(fetch_en, 1'b0, "fetch not stopped");
        end
        u_febs_pipe_model.step('0, '0);
        chk(fetch_en, 1'b1, "fetch not resumed");
        chk(count_inc, 1'b0, "count after queue drained");
        $display("test_queue_full done");
    endtask

    // One decode; a slow one gets a second offer while busy, which must be ignored.
    task automatic decode(input febs_insn_s i, input int lat);
        int at;
        int dones;
        int cnt;
        int slw;
        int ecnt;
        at = 0;
        dones = 0;
        cnt = 0;
        slw = 0;
        ecnt = (lat == 6) ? 6 : 0;
        sel = {EVT_LDSLOW, UM_NONE};
        u_febs_pipe_model.step('0, i);
        for (int n = 1; n <= 8; n++) begin
            u_febs_pipe_model.step('0, (n == 2 && lat == 6) ? i : '0);
            if (count_inc === 1'b1) cnt++;
            if (ld_slow === 1'b1) slw++;
            if (ld_done === 1'b1) begin
                dones++;
                if (at == 0) at = n;
            end
        end
        tests_run++;
        if (at != lat || dones != 1 || slw != lat - 1 || cnt != ecnt) begin
            mismatches++;
            $display("unexpected at %0t: latency %0d count %0d slow %0d", $time, at, cnt, slw);
        end
    endtask

    task automatic test_decode();
        decode(mk(PFX_OPSIZE, 1'b1, 1'b0, FEBS_MODE_REAL), 6);
        decode(mk(PFX_OPSIZE, 1'b0, 1'b0, FEBS_MODE_REAL), 1);
        for (int m = 0; m < 4; m++) begin
            decode(mk(PFX_ADSIZE, 1'b0, 1'b1, febs_mode_e'(m)), 6);
        end
        decode(mk(PFX_ADSIZE, 1'b0, 1'b0, FEBS_MODE_PROT32), 1);
        $display("test_decode done");
    endtask

    // Reset in mid slow decode drops it; the decoder then takes a fresh offer.
    task automatic test_reset_abort();
        sel = {EVT_LDSLOW, UM_NONE};
        u_febs_pipe_model.step('0, mk(PFX_OPSIZE, 1'b1, 1'b0, FEBS_MODE_PROT16));
        u_febs_pipe_model.step('0, '0);
        u_febs_pipe_model.step('0, '0);
        chk(ld_slow, 1'b1, "slow decode not running");
        arst_n = 1'b0;
        u_febs_pipe_model.step('0, '0);
        chk(ld_slow, 1'b0, "slow decode kept through reset");
        chk(count_inc, 1'b0, "count kept through reset");
        chk(fetch_en, 1'b1, "fetch held off in reset");
        arst_n = 1'b1;
        decode(mk(PFX_ADSIZE, 1'b0, 1'b1, FEBS_MODE_BIGREAL), 6);
        $display("test_reset_abort done");
    endtask

    // The scenarios need about 114 cycles; this leaves a wide margin.
    initial begin
        #20000;
        mismatches++;
        print_verdict();
    end

    initial begin
        mismatches = 0;
        tests_run = 0;
        arst_n = 1'b0;
        sel = '0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk(fetch_en, 1'b1, "fetch enable in reset");
        chk(ld_done, 1'b0, "decode done in reset");
        chk(ld_slow, 1'b0, "slow decode in reset");
        chk(count_inc, 1'b0, "count in reset");
        arst_n = 1'b1;
        test_codes();
        test_queue_full();
        test_decode();
        test_reset_abort();
        print_verdict();
    end
endmodule
